//--- rtl/pfc_credit_readout.sv
// module: flow control credit counters and selectable readout
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - header credit one TLP header, data 16 bytes
// - initial rx header credits per pool and level
// - initial rx data credits by level and payload
// - exhausted rx available space reads zero
// - rx available returns to initial when drained
// - six outputs, 8-bit header, 12-bit data
// - selector codes pick view, two reserved
// - selector may change every cycle, no handshake
// - latency two cycles 64-bit, four 128-bit
// - credit value encoding ordinary, negative, infinite
// - negative or infinite only in tx available
// - view 000 shows free local receive space
// - view 001 shows allocated, grows on readout
// - infinite advertised pool reads zero limit
// - view 010 shows received, starts at zero
// - endpoint advertises infinite completion credits
// - view 100 shows partner space, may be negative
// - view 101 partner limit, infinite reads zero
// - view 110 counts credits consumed on transmit
module pfc_credit_readout
   import pfc_pkg::*;
#(
   parameter int DATAPATH_W = DP_64,
   parameter bit PERF_HIGH = 1'b0,
   parameter logic [1:0] MAX_PAYLOAD = MPS_128,
   parameter bit IS_ENDPOINT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic link_up,
   input wire logic [2:0] credit_view_select,
   // receive events: credits per pool entering and drained
   input wire logic rx_enter,
   input wire logic [2:0] rx_enter_pool,
   input wire logic [7:0] rx_enter_hdr,
   input wire logic [11:0] rx_enter_data,
   input wire logic rx_drain,
   input wire logic [2:0] rx_drain_pool,
   input wire logic [7:0] rx_drain_hdr,
   input wire logic [11:0] rx_drain_data,
   // transmit side figures supplied by link logic
   input wire logic tx_init,
   input wire logic [2:0] tx_inf_pools,
   input wire logic [7:0] tx_init_ph,
   input wire logic [11:0] tx_init_pd,
   input wire logic [7:0] tx_init_nph,
   input wire logic [11:0] tx_init_npd,
   input wire logic [7:0] tx_init_ch,
   input wire logic [11:0] tx_init_cd,
   input wire logic tx_update,
   input wire logic [2:0] tx_update_pool,
   input wire logic [7:0] tx_update_hdr,
   input wire logic [11:0] tx_update_data,
   input wire logic tx_send,
   input wire logic [2:0] tx_send_pool,
   input wire logic [7:0] tx_send_hdr,
   input wire logic [11:0] tx_send_data,
   output logic [7:0] posted_header_credits,
   output logic [11:0] posted_data_credits,
   output logic [7:0] nonposted_header_credits,
   output logic [11:0] nonposted_data_credits,
   output logic [7:0] completion_header_credits,
   output logic [11:0] completion_data_credits
);

   localparam int LAT = (DATAPATH_W == DP_128) ? LAT_128 : LAT_64;

   // pool widths: even index header, odd data; all held at 12 bits
   logic [11:0] init_rx [POOLS];
   logic [11:0] rx_lim_q [POOLS];
   logic [11:0] rx_rcv_q [POOLS];
   logic [11:0] tx_lim_q [POOLS];
   logic [11:0] tx_cons_q [POOLS];
   logic [POOLS-1:0] tx_inf_q;
   logic [11:0] view_d [POOLS];
   logic [11:0] pipe_q [LAT][POOLS];

   // initial credit table selection
   function automatic logic [11:0] init_data(input logic high,
                                             input logic [1:0] mps);
      logic [11:0] v;
      v = DAT_ZERO;
      if (mps == MPS_128) begin
         v = high ? INIT_D_HIGH_128 : INIT_D_GOOD_128;
      end else if (mps == MPS_256) begin
         v = high ? INIT_D_HIGH_256 : INIT_D_GOOD_256;
      end else if (mps == MPS_512) begin
         v = high ? INIT_D_HIGH_512 : INIT_D_GOOD_512;
      end else begin
         v = high ? INIT_D_HIGH_1K : INIT_D_GOOD_1K;
      end
      return v;
   endfunction : init_data

   // header pool index test, data is the odd slot
   function automatic logic is_hdr(input int p);
      return (p % 2) == 0;
   endfunction : is_hdr

   // counters are in credit units: one header or 16 payload bytes
   always_comb begin
      init_rx[P_PH] = {4'h0, PERF_HIGH ? INIT_PH_HIGH : INIT_PH_GOOD};
      init_rx[P_NPH] = {4'h0, INIT_NPH};
      init_rx[P_CH] = {4'h0, PERF_HIGH ? INIT_CH_HIGH : INIT_CH_GOOD};
      init_rx[P_PD] = init_data(PERF_HIGH, MAX_PAYLOAD);
      init_rx[P_NPD] = INIT_NPD;
      init_rx[P_CD] = init_data(PERF_HIGH, MAX_PAYLOAD);
   end

   genvar g;
   generate
      for (g = 0; g < POOLS; g++) begin : g_pool
         localparam logic [2:0] PIDX = 3'(g / 2); // pool number of slot
         logic [11:0] enter_amt;
         logic [11:0] drain_amt;
         logic [11:0] upd_amt;
         logic [11:0] send_amt;
         logic [11:0] tx_init_v;
         logic [11:0] rx_free;
         logic [11:0] tx_free;
         logic [11:0] mask;
         assign mask = is_hdr(g) ? 12'h0ff : 12'hfff;
         assign enter_amt = is_hdr(g) ? {4'h0, rx_enter_hdr} : rx_enter_data;
         assign drain_amt = is_hdr(g) ? {4'h0, rx_drain_hdr} : rx_drain_data;
         assign upd_amt = is_hdr(g) ? {4'h0, tx_update_hdr} : tx_update_data;
         assign send_amt = is_hdr(g) ? {4'h0, tx_send_hdr} : tx_send_data;
         assign tx_init_v = (g == P_PH) ? {4'h0, tx_init_ph} :
                            (g == P_PD) ? tx_init_pd :
                            (g == P_NPH) ? {4'h0, tx_init_nph} :
                            (g == P_NPD) ? tx_init_npd :
                            (g == P_CH) ? {4'h0, tx_init_ch} : tx_init_cd;

         // allocated limit grows as TLPs leave over the receive stream
         always_ff @(posedge ref_clk) begin
            if (rst || !link_up) begin
               rx_lim_q[g] <= init_rx[g];
            end else if (rx_drain && rx_drain_pool == PIDX) begin
               rx_lim_q[g] <= (rx_lim_q[g] + drain_amt) & mask;
            end
         end

         // received count grows as packets enter receive buffers
         always_ff @(posedge ref_clk) begin
            if (rst || !link_up) begin
               rx_rcv_q[g] <= DAT_ZERO;
            end else if (rx_enter && rx_enter_pool == PIDX) begin
               rx_rcv_q[g] <= (rx_rcv_q[g] + enter_amt) & mask;
            end
         end

         // partner limit and infinite marking
         always_ff @(posedge ref_clk) begin
            if (rst || !link_up) begin
               tx_lim_q[g] <= DAT_ZERO;
               tx_inf_q[g] <= 1'b0;
            end else if (tx_init) begin
               tx_lim_q[g] <= tx_init_v & mask;
               tx_inf_q[g] <= tx_inf_pools[g/2];
            end else if (tx_update && tx_update_pool == PIDX) begin
               tx_lim_q[g] <= (tx_lim_q[g] + upd_amt) & mask;
            end
         end

         // consumed count grows as packets go to the partner
         always_ff @(posedge ref_clk) begin
            if (rst || !link_up) begin
               tx_cons_q[g] <= DAT_ZERO;
            end else if (tx_send && tx_send_pool == PIDX) begin
               tx_cons_q[g] <= (tx_cons_q[g] + send_amt) & mask;
            end
         end

         // free space, modular difference; receive side clamps at zero
         assign rx_free = (rx_lim_q[g] - rx_rcv_q[g]) & mask;
         assign tx_free = (tx_lim_q[g] - tx_cons_q[g]) & mask;

         // view mux for this pool
         always_comb begin
            view_d[g] = DAT_ZERO;
            case (pfc_view_t'(credit_view_select))
               PFC_RX_AVAIL: begin
                  // sign bit set means space used up: show zero
                  if (is_hdr(g) ? rx_free[7] : rx_free[11]) begin
                     view_d[g] = DAT_ZERO;
                  end else begin
                     view_d[g] = rx_free;
                  end
               end
               PFC_RX_LIMIT: begin
                  if (IS_ENDPOINT && g >= P_CH) begin
                     view_d[g] = DAT_ZERO;
                  end else begin
                     view_d[g] = rx_lim_q[g];
                  end
               end
               PFC_RX_CONS: view_d[g] = rx_rcv_q[g];
               PFC_TX_AVAIL: begin
                  if (tx_inf_q[g]) begin
                     view_d[g] = is_hdr(g) ? {4'h0, HDR_INF} : DAT_INF;
                  end else begin
                     view_d[g] = tx_free;
                  end
               end
               PFC_TX_LIMIT:
                  view_d[g] = tx_inf_q[g] ? DAT_ZERO : tx_lim_q[g];
               PFC_TX_CONS: view_d[g] = tx_cons_q[g];
               default: view_d[g] = DAT_ZERO;
            endcase
         end

         // output pipeline sets select-to-output latency
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               for (int s = 0; s < LAT; s++) begin
                  pipe_q[s][g] <= DAT_ZERO;
               end
            end else begin
               pipe_q[0][g] <= view_d[g];
               for (int s = 1; s < LAT; s++) begin
                  pipe_q[s][g] <= pipe_q[s-1][g];
               end
            end
         end
      end
   endgenerate

   // outputs straight from final pipeline stage
   assign posted_header_credits = pipe_q[LAT-1][P_PH][7:0];
   assign posted_data_credits = pipe_q[LAT-1][P_PD];
   assign nonposted_header_credits = pipe_q[LAT-1][P_NPH][7:0];
   assign nonposted_data_credits = pipe_q[LAT-1][P_NPD];
   assign completion_header_credits = pipe_q[LAT-1][P_CH][7:0];
   assign completion_data_credits = pipe_q[LAT-1][P_CD];

endmodule : pfc_credit_readout

`default_nettype wire

//--- rtl/pfc_pkg.sv
// package: constants and types for the flow credit readout block
package pfc_pkg;
   localparam int HDR_W = 8;
   localparam int DAT_W = 12;
   localparam int DATA_CREDIT_BYTES = 16;
   localparam int POOLS = 6;
   // datapath widths and their select latencies
   localparam int DP_64 = 64;
   localparam int DP_128 = 128;
   localparam int LAT_64 = 2;
   localparam int LAT_128 = 4;
   // view selector codes
   typedef enum logic [2:0] {
      PFC_RX_AVAIL = 3'b000,
      PFC_RX_LIMIT = 3'b001,
      PFC_RX_CONS = 3'b010,
      PFC_RSVD_A = 3'b011,
      PFC_TX_AVAIL = 3'b100,
      PFC_TX_LIMIT = 3'b101,
      PFC_TX_CONS = 3'b110,
      PFC_RSVD_B = 3'b111
   } pfc_view_t;
   // pool index order
   localparam int P_PH = 0;
   localparam int P_PD = 1;
   localparam int P_NPH = 2;
   localparam int P_NPD = 3;
   localparam int P_CH = 4;
   localparam int P_CD = 5;
   // initial receive credits
   localparam logic [7:0] INIT_NPH = 8'h0c;
   localparam logic [11:0] INIT_NPD = 12'h00c;
   localparam logic [7:0] INIT_PH_GOOD = 8'h20;
   localparam logic [7:0] INIT_PH_HIGH = 8'h34;
   localparam logic [7:0] INIT_CH_GOOD = 8'h1a;
   localparam logic [7:0] INIT_CH_HIGH = 8'h32;
   localparam logic [11:0] INIT_D_GOOD_128 = 12'h04d;
   localparam logic [11:0] INIT_D_GOOD_256 = 12'h04d;
   localparam logic [11:0] INIT_D_GOOD_512 = 12'h09a;
   localparam logic [11:0] INIT_D_GOOD_1K = 12'h134;
   localparam logic [11:0] INIT_D_HIGH_128 = 12'h09a;
   localparam logic [11:0] INIT_D_HIGH_256 = 12'h09a;
   localparam logic [11:0] INIT_D_HIGH_512 = 12'h134;
   localparam logic [11:0] INIT_D_HIGH_1K = 12'h268;
   // transmit infinite encodings, zero values and payload size codes
   localparam logic [7:0] HDR_INF = 8'h7f;
   localparam logic [11:0] DAT_INF = 12'h7ff;
   localparam logic [7:0] HDR_ZERO = 8'h00;
   localparam logic [11:0] DAT_ZERO = 12'h000;
   localparam logic [1:0] MPS_128 = 2'h0;
   localparam logic [1:0] MPS_256 = 2'h1;
   localparam logic [1:0] MPS_512 = 2'h2;
endpackage : pfc_pkg

//--- test/pfc_credit_readout_tb.sv
// testbench: scenarios for the flow credit readout
`timescale 1ns/1ps
`default_nettype none
module pfc_credit_readout_tb
   import pfc_pkg::*;
;
   logic ref_clk, rst, link_up;
   logic [2:0] want_view, sel, ev_pool, inf;
   logic [4:0] stb;
   logic [7:0] ev_hdr, ph, nph, ch;
   logic [11:0] ev_data, pd, npd, cd;
   logic [59:0] seen, init_av;
   int bad_count, n_checks;
   assign seen = {ph, pd, nph, npd, ch, cd};
   // strobes: 0 enter, 1 drain, 2 update, 3 send, 4 partner init
   pfc_credit_readout #(.DATAPATH_W(DP_64), .PERF_HIGH(1'b0),
      .MAX_PAYLOAD(MPS_128), .IS_ENDPOINT(1'b1)) DUT (.ref_clk(ref_clk),
      .rst(rst), .link_up(link_up), .credit_view_select(sel),
      .rx_enter(stb[0]), .rx_enter_pool(ev_pool), .rx_enter_hdr(ev_hdr),
      .rx_enter_data(ev_data), .rx_drain(stb[1]), .rx_drain_pool(ev_pool),
      .rx_drain_hdr(ev_hdr), .rx_drain_data(ev_data), .tx_init(stb[4]),
      .tx_inf_pools(inf), .tx_init_ph(ev_hdr), .tx_init_pd(ev_data),
      .tx_init_nph(ev_hdr), .tx_init_npd(ev_data), .tx_init_ch(ev_hdr),
      .tx_init_cd(ev_data), .tx_update(stb[2]), .tx_update_pool(ev_pool),
      .tx_update_hdr(ev_hdr), .tx_update_data(ev_data), .tx_send(stb[3]),
      .tx_send_pool(ev_pool), .tx_send_hdr(ev_hdr), .tx_send_data(ev_data),
      .posted_header_credits(ph), .posted_data_credits(pd),
      .nonposted_header_credits(nph), .nonposted_data_credits(npd),
      .completion_header_credits(ch), .completion_data_credits(cd));
   pfc_user_model u_user (.ref_clk(ref_clk), .want_view(want_view),
      .credit_view_select(sel));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic cmp(input logic [59:0] e);
      n_checks++;
      if (seen !== e) begin
         bad_count++;
         $display("[ERR] credits view %0d exp %h got %h", want_view, e, seen);
      end
   endtask : cmp
   // pick a view, then judge it once the two-cycle pipe has filled
   task automatic look(input logic [2:0] v, input logic [59:0] e);
      @(posedge ref_clk);
      want_view <= v;
      repeat (4) @(negedge ref_clk);
      cmp(e);
   endtask : look
   // one-cycle event pulse with its pool and credit figures
   task automatic ev(input logic [4:0] s, input logic [2:0] p,
      input logic [7:0] h, input logic [11:0] d);
      @(negedge ref_clk);
      stb = s;
      ev_pool = p;
      ev_hdr = h;
      ev_data = d;
      @(negedge ref_clk);
      stb = 5'h0;
   endtask : ev
   task automatic t_init();
      look(PFC_RX_AVAIL, init_av);
      look(PFC_RX_LIMIT, {init_av[59:20], 20'h0});
      look(PFC_RX_CONS, 60'h0);
      look(PFC_RSVD_A, 60'h0);
      look(PFC_RSVD_B, 60'h0);
   endtask : t_init
   task automatic t_rx();
      ev(5'h01, 3'h0, 8'h04, 12'h008);
      look(PFC_RX_AVAIL, {8'h1c, 12'h045, init_av[39:0]});
      look(PFC_RX_CONS, {8'h04, 12'h008, 40'h0});
      ev(5'h02, 3'h0, 8'h04, 12'h008);
      look(PFC_RX_AVAIL, init_av);
      look(PFC_RX_LIMIT, {8'h24, 12'h055, init_av[39:20], 20'h0});
   endtask : t_rx
   task automatic t_full();
      ev(5'h01, 3'h1, 8'h0d, 12'h00d);
      look(PFC_RX_AVAIL, {init_av[59:40], 20'h0, init_av[19:0]});
      ev(5'h02, 3'h1, 8'h0d, 12'h00d);
      look(PFC_RX_AVAIL, init_av);
   endtask : t_full
   task automatic t_tx();
      ev(5'h10, 3'h0, 8'h02, 12'h005);
      look(PFC_TX_AVAIL, {40'h02005_02005, HDR_INF, DAT_INF});
      look(PFC_TX_LIMIT, {40'h02005_02005, 20'h0});
      ev(5'h08, 3'h1, 8'h03, 12'h001);
      look(PFC_TX_AVAIL, {40'h02005_ff004, HDR_INF, DAT_INF});
      look(PFC_TX_CONS, {40'h00000_03001, 20'h0});
      ev(5'h04, 3'h0, 8'h05, 12'h000);
      look(PFC_TX_LIMIT, {40'h07005_02005, 20'h0});
   endtask : t_tx
   // views changed on three cycles in a row, each seen two cycles on
   task automatic t_sweep();
      cmp({40'h07005_02005, 20'h0});
      @(posedge ref_clk);
      want_view <= PFC_RX_CONS;
      @(posedge ref_clk);
      want_view <= PFC_RSVD_B;
      @(posedge ref_clk);
      want_view <= PFC_RX_AVAIL;
      @(negedge ref_clk);
      cmp({40'h04008_0d00d, 20'h0});
      @(negedge ref_clk);
      cmp(60'h0);
      @(negedge ref_clk);
      cmp(init_av);
   endtask : t_sweep
   initial begin
      rst = 1'b1;
      link_up = 1'b0;
      want_view = PFC_RX_AVAIL;
      stb = 5'h0;
      ev_pool = 3'h0;
      ev_hdr = 8'h00;
      ev_data = 12'h000;
      inf = 3'b100;
      init_av = {INIT_PH_GOOD, INIT_D_GOOD_128, INIT_NPH, INIT_NPD,
         INIT_CH_GOOD, INIT_D_GOOD_128};
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      t_init();
      link_up = 1'b1;
      t_init();
      t_rx();
      t_full();
      t_tx();
      t_sweep();
      stop_test();
   end
   // guard against a hung run
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule : pfc_credit_readout_tb
`default_nettype wire

//--- test/pfc_readout_sva.sv
// checker: timing and value relations at the credit readout ports
`timescale 1ns/1ps
`default_nettype none
module pfc_readout_sva
   import pfc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic link_up,
   input wire logic [2:0] credit_view_select,
   input wire logic [7:0] posted_header_credits,
   input wire logic [11:0] posted_data_credits,
   input wire logic [7:0] nonposted_header_credits,
   input wire logic [11:0] nonposted_data_credits,
   input wire logic [7:0] completion_header_credits,
   input wire logic [11:0] completion_data_credits
);
   localparam logic [59:0] AV0 = {INIT_PH_GOOD, INIT_D_GOOD_128, INIT_NPH,
      INIT_NPD, INIT_CH_GOOD, INIT_D_GOOD_128};
   logic [2:0] sel;
   logic [2:0] hm;
   logic [2:0] dm;
   logic [59:0] all_c;
   // short names for the selector, all outputs and their sign bits
   assign sel = credit_view_select;
   assign all_c = {posted_header_credits, posted_data_credits,
      nonposted_header_credits, nonposted_data_credits,
      completion_header_credits, completion_data_credits};
   assign hm = {all_c[59], all_c[39], all_c[19]};
   assign dm = {all_c[51], all_c[31], all_c[11]};
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   AST_RSVD_ZERO: assert property (
      sel[1:0] == 2'b11 |-> ##2 all_c == 60'h0)
      else $error("reserved view gave nonzero credits");
   AST_RX_HDR_SIGN: assert property (
      sel inside {3'b000, 3'b001, 3'b010} |-> ##2 hm == 3'b000)
      else $error("receive view header credit negative");
   AST_RX_DAT_SIGN: assert property (
      !sel[2] && sel[1:0] != 2'b11 |-> ##2 !(|dm))
      else $error("receive view data credit negative");
   AST_TX_CNT_SIGN: assert property (
      sel inside {3'b101, 3'b110} |-> ##2 (hm | dm) == 3'b000)
      else $error("transmit limit or consumed negative");
   AST_CONS_IDLE: assert property (
      (!link_up && sel == PFC_RX_CONS) [*2] |-> ##2 all_c == 60'h0)
      else $error("receive consumed not zero before link up");
   AST_AVAIL_INIT: assert property (
      (!link_up && sel == PFC_RX_AVAIL) [*2] |-> ##2 all_c == AV0)
      else $error("receive available not at initial credits");
   AST_LIMIT_INIT: assert property (
      (!link_up && sel == PFC_RX_LIMIT) [*2] |-> ##2 all_c[59:20] == AV0[59:20])
      else $error("receive limit not at advertised credits");
   AST_EP_CPL_LIM: assert property (
      sel == PFC_RX_LIMIT |-> ##2 all_c[19:0] == 20'h0)
      else $error("infinite completion pool limit not zero");
   // main scenarios reached
   cover property (sel == PFC_TX_AVAIL ##2 all_c[19:12] == HDR_INF);
   cover property (sel == PFC_RX_AVAIL ##2 all_c[39:32] == 8'h00);
   cover property ($rose(link_up));
endmodule : pfc_readout_sva
bind pfc_credit_readout pfc_readout_sva u_sva (.ref_clk(ref_clk),
   .rst(rst), .link_up(link_up), .credit_view_select(credit_view_select),
   .posted_header_credits(posted_header_credits),
   .posted_data_credits(posted_data_credits),
   .nonposted_header_credits(nonposted_header_credits),
   .nonposted_data_credits(nonposted_data_credits),
   .completion_header_credits(completion_header_credits),
   .completion_data_credits(completion_data_credits));
`default_nettype wire

//--- test/pfc_user_model.sv
// user model: user logic that picks the credit view
`timescale 1ns/1ps
`default_nettype none
module pfc_user_model (
   input wire logic ref_clk,
   input wire logic [2:0] want_view,
   output logic [2:0] credit_view_select
);
   // a new view may go out on any cycle, launched off the falling edge
   initial credit_view_select = 3'h0;
   always @(negedge ref_clk) credit_view_select <= want_view;
endmodule : pfc_user_model
`default_nettype wire
